// >>> hw/ppo_pkg.sv
// Constants, register map and mode codes of the pulse output block.
// Assumes a 20 MHz APB clock and a one-pulse-per-second epoch input.
package ppo_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned TICK_MS      = 10;
  localparam int unsigned CYC_TICK     = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned IRIG_ZERO_MS = 2;
  localparam int unsigned IRIG_ONE_MS  = 5;
  localparam int unsigned IRIG_MARK_MS = 8;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] A_CTRL  = 12'h000;
  localparam logic [11:0] A_WIDTH = 12'h004;
  localparam logic [11:0] A_PER   = 12'h008;
  localparam logic [11:0] A_HOFF  = 12'h00C;
  localparam logic [11:0] A_DAY   = 12'h010;
  localparam logic [11:0] A_TRGT  = 12'h014;
  localparam logic [11:0] A_TRGD  = 12'h018;
  localparam logic [11:0] A_LOFF  = 12'h01C;
  localparam logic [11:0] A_DSTA  = 12'h020;
  localparam logic [11:0] A_DSTO  = 12'h024;
  localparam logic [11:0] A_TIME  = 12'h028;
  localparam logic [11:0] A_CAL   = 12'h02C;
  localparam logic [11:0] A_STAT  = 12'h030;
  // ----------------------------------------------------------------
  // Control fields and time packing
  // ----------------------------------------------------------------
  localparam int C_POL      = 3;
  localparam int C_ZONE     = 4;
  localparam int C_STD_LOC  = 5;
  localparam int C_STD_C37  = 6;
  localparam int C_AUX_LOC  = 7;
  localparam int C_AUX_C37  = 8;
  localparam int C_DST      = 9;
  localparam int C_TRIG_CLR = 11;
  localparam int C_SEL      = 12;
  localparam int T_H        = 19;
  localparam int T_M        = 13;
  localparam int T_S        = 7;
  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [17:0] CTRL_RST   = 18'h0_0001;
  localparam logic [23:0] WIDTH_RST  = 24'h00_0001;
  localparam logic [23:0] WIDTH_MAX  = 24'h83_D600;
  localparam logic [23:0] WIDTH_HD   = 24'h00_EA60;
  localparam logic [15:0] PER_MAX    = 16'hEA60;
  localparam logic [11:0] HOFF_MAX   = 12'h0E0F;
  localparam logic [6:0]  FRAC_LAST  = 7'h63;
  localparam logic [6:0]  FRAC_HALF  = 7'h32;
  localparam logic [5:0]  SLOW_MIN_S = 6'h02;
  localparam logic [5:0]  SLOW_HR_S  = 6'h04;
  localparam logic [5:0]  SLOW_DAY_S = 6'h06;
  localparam logic [6:0]  LW_ZERO    = 7'h0A;
  localparam logic [6:0]  LW_ONE     = 7'h14;
  localparam logic [6:0]  LW_LAST    = 7'h32;
  localparam logic [1:0]  SEL_PULSE  = 2'h0;
  localparam logic [1:0]  SEL_IRIG   = 2'h1;
  localparam logic [1:0]  SEL_EXT    = 2'h2;
  localparam logic [1:0]  DST_ON     = 2'h1;
  localparam logic [1:0]  DST_AUTO   = 2'h2;
  typedef enum logic [2:0] {
    M_AUX  = 3'h0, M_SPP  = 3'h1, M_HOUR = 3'h3, M_DAY   = 3'h2,
    M_TRIG = 3'h6, M_SLOW = 3'h7, M_LW   = 3'h5, M_LWMOD = 3'h4
  } ppo_mode_t;
endpackage

// >>> hw/ppo_top.sv
// Programmable timing pulse output with APB register slave.
// Assumes pps_in and ext_src are asynchronous pins; all else on pclk.
// How it works
// RULE_01: Mode field picks one of eight generators
// RULE_02: Polarity bit inverts the generated pulse, except in slow code mode
// RULE_03: Width in 10 ms ticks, clamped to 24 h
// RULE_04: Seconds-per-pulse every N seconds, N 1..60000
// RULE_05: Hourly pulse at offset seconds past hour
// RULE_06: Hourly and daily widths capped at 600 s
// RULE_07: Daily pulse on hour/minute/second/fraction match
// RULE_08: Trigger instant is date and time, UTC/local
// RULE_09: Fired trigger holds opposite level until cleared
// RULE_10: Slow code low 2/4/6 s at minute/hour/day
// RULE_11: Modified long-wave sends second 59 as 0.5 s
// RULE_12: Auxiliary time code with own zone and extension
// RULE_13: Standard time code zone and extension for ports
// RULE_14: Each of three ports selects pulse or other source
// RULE_15: Local time is UTC plus offset plus DST
// RULE_16: Edges aligned to the second epoch, 10 ms steps
`timescale 1ns/10ps
`default_nettype none
module ppo_top #(
  parameter int unsigned TICK_CYC = ppo_pkg::CYC_TICK,
  parameter int unsigned NPORT    = 3
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output var  logic [31:0]      prdata,
  output var  logic             pready,
  output var  logic             pslverr,
  input  wire logic             pps_in,
  input  wire logic [NPORT-1:0] ext_src,
  output var  logic             pulse_out,
  output var  logic [NPORT-1:0] port_out
);
  // ----------------------------------------------------------------
  // Constants and state
  // ----------------------------------------------------------------
  localparam int unsigned CW = $clog2(TICK_CYC);
  localparam logic [CW-1:0] T_LAST = CW'(TICK_CYC - 1);
  localparam logic [CW-1:0] I_W0 = CW'(TICK_CYC * ppo_pkg::IRIG_ZERO_MS / ppo_pkg::TICK_MS);
  localparam logic [CW-1:0] I_W1 = CW'(TICK_CYC * ppo_pkg::IRIG_ONE_MS / ppo_pkg::TICK_MS);
  localparam logic [CW-1:0] I_WM = CW'(TICK_CYC * ppo_pkg::IRIG_MARK_MS / ppo_pkg::TICK_MS);

  logic             pps_s1_q, pps_s2_q, pps_s3_q;
  logic [NPORT-1:0] ext_s1_q, ext_s2_q;
  logic [CW-1:0]    cyc_q;
  logic [6:0]       frac_q;
  logic [5:0]       sec_q, min_q;
  logic [4:0]       hour_q;
  logic [17:0]      ctrl_q;
  logic [23:0]      width_q, day_q, trgt_q, wid_q;
  logic [15:0]      per_q, spp_q;
  logic [11:0]      hoff_q;
  logic [8:0]       trgd_q;
  logic [4:0]       loff_q;
  logic [20:0]      dsta_q, dsto_q;
  logic [18:0]      cal_q;
  logic             act_q, fired_q;
  logic [31:0]      rd_d;
  logic             map_ok;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] bcd(input logic [5:0] v);
    logic [5:0] t;
    t = v / 6'd10;
    return {t[3:0], 4'(v - t * 6'd10)};
  endfunction

  function automatic logic [4:0] loc_h(input logic [4:0] h, input logic [4:0] off,
                                       input logic dst);
    logic signed [6:0] s;
    s = $signed({2'b00, h}) + $signed({{2{off[4]}}, off}) + $signed({6'd0, dst});
    if (s < 0) begin
      s = s + 7'sd24;
    end else if (s > 7'sd23) begin
      s = s - 7'sd24;
    end
    return s[4:0];
  endfunction

  function automatic logic irig_lvl(input logic [6:0] idx, input logic [CW-1:0] c,
                                    input logic [4:0] h, input logic [5:0] m,
                                    input logic [5:0] s, input logic ext,
                                    input logic dst);
    logic [7:0] f;
    logic [3:0] u, k, d;
    logic       b;
    u = 4'(idx % 7'd10);
    d = 4'(idx / 7'd10);
    f = (d == 4'd0) ? bcd(s) : (d == 4'd1) ? bcd(m) : bcd({1'b0, h});
    k = (d == 4'd0) ? u - 4'd1 : u;
    b = 1'b0;
    if (d < 4'd3) begin
      if (k < 4'd4) begin
        b = f[k[2:0]];
      end else if (k > 4'd4 && k < 4'd8) begin
        b = f[3'(k - 4'd1)];
      end
    end else if (d == 4'd6 && u == 4'd0) begin
      b = ext & dst;
    end
    if (idx == 7'd0 || u == 4'd9) begin
      return c < I_WM;
    end
    return c < (b ? I_W1 : I_W0);
  endfunction

  function automatic logic lw_bit(input logic [5:0] s, input logic [5:0] m,
                                  input logic [4:0] h, input logic dst);
    logic [7:0] bm, bh;
    logic [5:0] i;
    bm = bcd(m);
    bh = bcd({1'b0, h});
    i = 6'd0;
    if (s == 6'd17) return dst;
    if (s == 6'd18) return ~dst;
    if (s == 6'd20) return 1'b1;
    if (s >= 6'd21 && s <= 6'd27) begin
      i = s - 6'd21;
      return bm[i[2:0]];
    end
    if (s == 6'd28) return ^bm[6:0];
    if (s >= 6'd29 && s <= 6'd34) begin
      i = s - 6'd29;
      return bh[i[2:0]];
    end
    if (s == 6'd35) return ^bh[5:0];
    return 1'b0;
  endfunction

  // ----------------------------------------------------------------
  // Time base and local time
  // ----------------------------------------------------------------
  wire ppo_pkg::ppo_mode_t mode = ppo_pkg::ppo_mode_t'(ctrl_q[2:0]);
  wire        pol      = ctrl_q[ppo_pkg::C_POL];
  wire [1:0]  dst_mode = ctrl_q[ppo_pkg::C_DST +: 2];
  wire        setup    = psel & ~penable & ~pready;
  wire        wr_en    = psel & penable & pwrite & pready;
  wire        time_wr  = wr_en & (paddr == ppo_pkg::A_TIME);
  wire        trig_clr = wr_en & (paddr == ppo_pkg::A_CTRL) & pwdata[ppo_pkg::C_TRIG_CLR];
  wire        tick     = cyc_q == T_LAST;
  wire        pps_rise = pps_s2_q & ~pps_s3_q;
  wire        tk       = tick | pps_rise; // [RULE_16]
  // Late epoch only realigns; an early one also closes the second
  wire        epoch    = (tick & (frac_q == ppo_pkg::FRAC_LAST))
                       | (pps_rise & (frac_q >= ppo_pkg::FRAC_HALF)); // [RULE_16]
  wire        s_end    = sec_q == 6'd59;
  wire        m_end    = min_q == 6'd59;
  wire [6:0]  frac_d   = (pps_rise | (frac_q == ppo_pkg::FRAC_LAST)) ? 7'd0 : frac_q + 7'd1;
  wire [5:0]  sec_d    = epoch ? (s_end ? 6'd0 : sec_q + 6'd1) : sec_q;
  wire [5:0]  min_d    = (epoch & s_end) ? (m_end ? 6'd0 : min_q + 6'd1) : min_q;
  wire        h_step   = epoch & s_end & m_end;
  wire [4:0]  hour_d   = h_step ? ((hour_q == 5'd23) ? 5'd0 : hour_q + 5'd1) : hour_q;
  wire [10:0] mday     = {6'd0, hour_q} * 11'd60 + {5'd0, min_q};
  wire [20:0] key      = {cal_q[18:9], mday};
  wire        aft      = key >= dsta_q;
  wire        bef      = key < dsto_q;
  wire        dst_win  = (dsta_q <= dsto_q) ? (aft & bef) : (aft | bef); // [RULE_15]
  wire        dst      = (dst_mode == ppo_pkg::DST_ON)
                       | ((dst_mode == ppo_pkg::DST_AUTO) & dst_win); // [RULE_15]
  wire [4:0]  lhour    = loc_h(hour_q, loff_q, dst); // [RULE_15]
  wire [4:0]  ph_d     = ctrl_q[ppo_pkg::C_ZONE] ? loc_h(hour_d, loff_q, dst) : hour_d;

  // ----------------------------------------------------------------
  // Pulse generators
  // ----------------------------------------------------------------
  wire [11:0] soh_d    = {6'd0, min_d} * 12'd60 + {6'd0, sec_d};
  wire [23:0] tod_d    = {ph_d, min_d, sec_d, frac_d};
  wire spp_hit  = epoch & (spp_q == 16'd0); // [RULE_04]
  wire hour_hit = epoch & (soh_d == hoff_q); // [RULE_05]
  wire day_hit  = tk & (tod_d == day_q); // [RULE_07]
  wire trig_hit = tk & ~fired_q & (mode == ppo_pkg::M_TRIG) & (tod_d == trgt_q)
                & (cal_q[8:0] == trgd_q); // [RULE_08]
  wire start    = (mode == ppo_pkg::M_SPP) ? spp_hit :
                  (mode == ppo_pkg::M_HOUR) ? hour_hit :
                  (mode == ppo_pkg::M_DAY) ? day_hit : 1'b0; // [RULE_01]
  wire hd       = (mode == ppo_pkg::M_HOUR) | (mode == ppo_pkg::M_DAY);
  wire [23:0] eff_w = (hd & (width_q > ppo_pkg::WIDTH_HD)) ? ppo_pkg::WIDTH_HD : width_q; // [RULE_06]
  wire [5:0]  slow_n = (hour_q == 5'd0 && min_q == 6'd0) ? ppo_pkg::SLOW_DAY_S :
                       (min_q == 6'd0) ? ppo_pkg::SLOW_HR_S : ppo_pkg::SLOW_MIN_S;
  wire slow_lo  = sec_q < slow_n; // [RULE_10]
  wire lw_mod   = mode == ppo_pkg::M_LWMOD;
  wire [6:0] lw_w = s_end ? (lw_mod ? ppo_pkg::LW_LAST : 7'd0) :
                    lw_bit(sec_q, min_q, lhour, dst) ? ppo_pkg::LW_ONE : ppo_pkg::LW_ZERO; // [RULE_11]
  wire lw_lvl   = frac_q < lw_w;
  wire aux_lvl  = irig_lvl(frac_q, cyc_q, ctrl_q[ppo_pkg::C_AUX_LOC] ? lhour : hour_q,
                           min_q, sec_q, ctrl_q[ppo_pkg::C_AUX_C37], dst); // [RULE_12]
  wire std_lvl  = irig_lvl(frac_q, cyc_q, ctrl_q[ppo_pkg::C_STD_LOC] ? lhour : hour_q,
                           min_q, sec_q, ctrl_q[ppo_pkg::C_STD_C37], dst); // [RULE_13]
  wire gen      = (mode == ppo_pkg::M_AUX) ? aux_lvl :
                  (mode == ppo_pkg::M_TRIG) ? fired_q :
                  ((mode == ppo_pkg::M_LW) | lw_mod) ? lw_lvl : act_q; // [RULE_01]
  // Slow code has a fixed idle-high sense, so polarity is not applied
  wire pulse_d  = (mode == ppo_pkg::M_SLOW) ? ~slow_lo : gen ^ pol; // [RULE_02] [RULE_10]
  logic [NPORT-1:0] port_d;

  for (genvar i = 0; i < NPORT; i++) begin : g_port
    wire [1:0] sel = ctrl_q[ppo_pkg::C_SEL + 2 * i +: 2];
    assign port_d[i] = (sel == ppo_pkg::SEL_PULSE) ? pulse_d :
                       (sel == ppo_pkg::SEL_IRIG) ? std_lvl :
                       (sel == ppo_pkg::SEL_EXT) ? ext_s2_q[i] : 1'b0; // [RULE_14]
  end

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  always_comb begin
    rd_d   = 32'h0000_0000;
    map_ok = 1'b1;
    case (paddr)
      ppo_pkg::A_CTRL:  rd_d[17:0] = ctrl_q;
      ppo_pkg::A_WIDTH: rd_d[23:0] = width_q;
      ppo_pkg::A_PER:   rd_d[15:0] = per_q;
      ppo_pkg::A_HOFF:  rd_d[11:0] = hoff_q;
      ppo_pkg::A_DAY:   rd_d[23:0] = day_q;
      ppo_pkg::A_TRGT:  rd_d[23:0] = trgt_q;
      ppo_pkg::A_TRGD:  rd_d[8:0]  = trgd_q;
      ppo_pkg::A_LOFF:  rd_d[4:0]  = loff_q;
      ppo_pkg::A_DSTA:  rd_d[20:0] = dsta_q;
      ppo_pkg::A_DSTO:  rd_d[20:0] = dsto_q;
      ppo_pkg::A_TIME:  rd_d[23:0] = {hour_q, min_q, sec_q, frac_q};
      ppo_pkg::A_CAL:   rd_d[18:0] = cal_q;
      ppo_pkg::A_STAT:  rd_d[7:0]  = {1'b0, port_out, pulse_out, dst, fired_q, act_q};
      default:          map_ok     = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {pps_s1_q, pps_s2_q, pps_s3_q} <= 3'h0;
      ext_s1_q <= '0;
      ext_s2_q <= '0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0000_0000;
    end else if (ce) begin
      pps_s1_q <= pps_in;
      pps_s2_q <= pps_s1_q;
      pps_s3_q <= pps_s2_q;
      ext_s1_q <= ext_src;
      ext_s2_q <= ext_s1_q;
      pready   <= setup;
      pslverr  <= setup & ~map_ok;
      if (setup) prdata <= rd_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_q  <= '0;
      frac_q <= 7'h00;
      {hour_q, min_q, sec_q} <= 17'h0_0000;
    end else if (ce) begin
      if (time_wr) begin
        cyc_q  <= '0;
        frac_q <= 7'h00;
        {hour_q, min_q, sec_q} <= pwdata[23:7];
      end else if (tk) begin
        cyc_q  <= '0;
        frac_q <= frac_d;
        {hour_q, min_q, sec_q} <= {hour_d, min_d, sec_d};
      end else begin
        cyc_q <= cyc_q + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= ppo_pkg::CTRL_RST;
      width_q <= ppo_pkg::WIDTH_RST;
      per_q   <= 16'h0001;
      hoff_q  <= 12'h000;
      {day_q, trgt_q, trgd_q, loff_q} <= 62'h0000_0000_0000_0000;
      {dsta_q, dsto_q, cal_q} <= 61'h0000_0000_0000_0000;
    end else if (ce && wr_en) begin
      case (paddr)
        ppo_pkg::A_CTRL:  ctrl_q <= {pwdata[17:12], 1'b0, pwdata[10:0]};
        ppo_pkg::A_WIDTH: width_q <= (pwdata[23:0] == 24'h0) ? ppo_pkg::WIDTH_RST :
                                     (pwdata[31:24] != 8'h0 || pwdata[23:0] > ppo_pkg::WIDTH_MAX)
                                     ? ppo_pkg::WIDTH_MAX : pwdata[23:0]; // [RULE_03]
        ppo_pkg::A_PER:   per_q <= (pwdata[15:0] == 16'h0) ? 16'h0001 :
                                   (pwdata[15:0] > ppo_pkg::PER_MAX) ? ppo_pkg::PER_MAX
                                   : pwdata[15:0]; // [RULE_04]
        ppo_pkg::A_HOFF:  hoff_q <= (pwdata[11:0] > ppo_pkg::HOFF_MAX) ? ppo_pkg::HOFF_MAX
                                    : pwdata[11:0]; // [RULE_05]
        ppo_pkg::A_DAY:   day_q  <= pwdata[23:0];
        ppo_pkg::A_TRGT:  trgt_q <= pwdata[23:0];
        ppo_pkg::A_TRGD:  trgd_q <= pwdata[8:0];
        ppo_pkg::A_LOFF:  loff_q <= pwdata[4:0];
        ppo_pkg::A_DSTA:  dsta_q <= pwdata[20:0];
        ppo_pkg::A_DSTO:  dsto_q <= pwdata[20:0];
        ppo_pkg::A_CAL:   cal_q  <= pwdata[18:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {act_q, fired_q, wid_q, spp_q} <= 42'h000_0000_0000;
      pulse_out <= 1'b0;
      port_out  <= '0;
    end else if (ce) begin
      pulse_out <= pulse_d;
      port_out  <= port_d;
      if (start) begin
        act_q <= 1'b1;
        wid_q <= eff_w; // [RULE_03]
      end else if (tk && act_q) begin
        wid_q <= wid_q - 24'd1;
        if (wid_q == 24'd1) act_q <= 1'b0;
      end
      if (wr_en && paddr == ppo_pkg::A_PER) spp_q <= 16'h0000;
      else if (epoch) spp_q <= (spp_q == 16'h0) ? per_q - 16'd1 : spp_q - 16'd1; // [RULE_04]
      // Firing wins over a clear in the same cycle
      if (trig_hit) fired_q <= 1'b1; // [RULE_09]
      else if (trig_clr) fired_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_epoch_align;
    ce && pps_rise && !time_wr |=> frac_q == 7'h00 && cyc_q == '0;
  endproperty
  a_epoch_align: assert property (p_epoch_align) else $error("epoch not aligned"); // [RULE_16]

  property p_hd_cap;
    ce && start && hd |=> act_q && wid_q <= ppo_pkg::WIDTH_HD && wid_q != 24'h0;
  endproperty
  a_hd_cap: assert property (p_hd_cap) else $error("width cap lost"); // [RULE_06]

  property p_width_range;
    act_q |-> wid_q != 24'h0 && wid_q <= ppo_pkg::WIDTH_MAX;
  endproperty
  a_width_range: assert property (p_width_range) else $error("width out of range"); // [RULE_03]

  property p_trig_hold;
    fired_q && !trig_clr |=> fired_q;
  endproperty
  a_trig_hold: assert property (p_trig_hold) else $error("trigger level lost"); // [RULE_09]

  property p_spp_reload;
    ce && spp_hit && !wr_en |=> spp_q == $past(per_q) - 16'd1;
  endproperty
  a_spp_reload: assert property (p_spp_reload) else $error("period reload wrong"); // [RULE_04]

  property p_slow_day;
    ce && mode == ppo_pkg::M_SLOW && hour_q == 5'd0 && min_q == 6'd0 && sec_q == 6'd5
      |=> !pulse_out;
  endproperty
  a_slow_day: assert property (p_slow_day) else $error("slow code day low"); // [RULE_10]

  property p_lw_mod59;
    ce && lw_mod && s_end && frac_q == 7'd40 |=> pulse_out == !pol;
  endproperty
  a_lw_mod59: assert property (p_lw_mod59) else $error("second 59 pulse"); // [RULE_11]

  property p_port_pulse;
    ce && ctrl_q[ppo_pkg::C_SEL +: 2] == ppo_pkg::SEL_PULSE |=> port_out[0] == pulse_out;
  endproperty
  a_port_pulse: assert property (p_port_pulse) else $error("port 0 not pulse"); // [RULE_14]

  property p_hour_start;
    ce && mode == ppo_pkg::M_HOUR && hour_hit |=> act_q && wid_q == $past(eff_w);
  endproperty
  a_hour_start: assert property (p_hour_start) else $error("hourly start"); // [RULE_05]

  property p_pol_spp;
    ce && mode == ppo_pkg::M_SPP && act_q && $stable(ctrl_q) |=> pulse_out == !$past(pol);
  endproperty
  a_pol_spp: assert property (p_pol_spp) else $error("polarity wrong"); // [RULE_02]
endmodule
`default_nettype wire

// >>> tb/ppo_rx.sv
// Receiver model for one timing output: measures high time and rise spacing.
// Assumes the line is sampled on the block clock and is synchronous to it.
`timescale 1ns/10ps
`default_nettype none
module ppo_rx (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        lvl,
  output var  logic [31:0] last_width,
  output var  logic [31:0] last_period
);
  // ----------------------------------------------------------------
  // Edge timing
  // ----------------------------------------------------------------
  logic        prev_q;
  logic [31:0] since_q;
  logic [31:0] hcnt_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q      <= 1'b0;
      since_q     <= 32'h0;
      hcnt_q      <= 32'h0;
      last_width  <= 32'h0;
      last_period <= 32'h0;
    end else begin
      prev_q  <= lvl;
      since_q <= since_q + 32'h1;
      if (lvl) hcnt_q <= hcnt_q + 32'h1;
      // Only whole cycles seen; sub-cycle skew is invisible
      if (lvl && !prev_q) begin
        last_period <= since_q + 32'h1;
        since_q     <= 32'h0;
        hcnt_q      <= 32'h1;
      end
      if (!lvl && prev_q) last_width <= hcnt_q;
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench: APB register checks, pulse timing, ports, trigger.
// Assumes a short tick of 20 cycles, so one second is 2000 cycles.
`timescale 1ns/10ps
`default_nettype none
module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pps_in = 1'b0;
  logic [2:0]  ext_src = 3'h0;
  logic        pulse_out;
  logic [2:0]  port_out;
  logic [31:0] last_width;
  logic [31:0] last_period;
  logic [11:0] pcnt = 12'h000;
  logic [31:0] q;
  logic        e;
  int          n_errors = 0;
  int          compares = 0;
  int          cyc = 0;
  logic [11:0] ra [8] = '{12'h004, 12'h004, 12'h004, 12'h008, 12'h008, 12'h00C, 12'h00C, 12'h000};
  logic [31:0] rw [8] = '{32'h0, 32'hFF_FFFF, 32'h5, 32'h0, 32'hFFFF, 32'hFFF, 32'h0, 32'h801};
  logic [31:0] re [8] = '{32'h1, 32'h83_D600, 32'h5, 32'h1, 32'hEA60, 32'hE0F, 32'h0, 32'h1};
  always #25 pclk = ~pclk;
  // Epoch every 100 ticks
  always @(posedge pclk) begin
    pcnt   <= (pcnt == 12'h7CF) ? 12'h000 : pcnt + 12'h001;
    pps_in <= (pcnt < 12'h00A);
  end
  ppo_top #(.TICK_CYC(20)) ppo_top_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pps_in(pps_in),
    .ext_src(ext_src), .pulse_out(pulse_out), .port_out(port_out));
  ppo_rx ppo_rx_inst (.clk(pclk), .rst_n(presetn), .lvl(port_out[0]),
    .last_width(last_width), .last_period(last_period));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Idle cycle first, so psel never gets two assignments in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Two cycles of slack for synchroniser and output lag
  function automatic logic [31:0] near(input logic [31:0] v, input logic [31:0] c);
    return {31'h0, (v + 32'h2 >= c) && (v <= c + 32'h2)};
  endfunction
  task automatic print_verdict();
    if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      check(q, 32'h1);
    end
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, ra[i], rw[i]);
      apb(1'b0, ra[i], 32'h0);
      check(q, re[i]);
    end
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, ppo_pkg::A_CTRL, 32'(m));
      apb(1'b0, ppo_pkg::A_CTRL, 32'h0);
      check(q, 32'(m));
    end
    apb(1'b0, 12'h040, 32'h0);
    check(q, 32'h0);
    check(32'(e), 32'h1);
    // Hourly: one second past the hour, width 7 ticks
    apb(1'b1, ppo_pkg::A_WIDTH, 32'h7);
    apb(1'b1, ppo_pkg::A_HOFF, 32'h1);
    apb(1'b1, ppo_pkg::A_TIME, 32'h7_7D80);
    apb(1'b1, ppo_pkg::A_CTRL, 32'h3);
    repeat (5000) @(posedge pclk);
    check(near(last_width, 32'h8C), 32'h1);
    apb(1'b1, ppo_pkg::A_WIDTH, 32'h3);
    apb(1'b1, ppo_pkg::A_PER, 32'h2);
    apb(1'b1, ppo_pkg::A_CTRL, 32'h1);
    repeat (10000) @(posedge pclk);
    check(near(last_width, 32'h3C), 32'h1);
    check(near(last_period, 32'hFA0), 32'h1);
    apb(1'b1, ppo_pkg::A_CTRL, 32'h9);
    repeat (10000) @(posedge pclk);
    check(near(last_width, 32'hF64), 32'h1);
    apb(1'b1, ppo_pkg::A_CTRL, 32'h3_8001);
    ext_src <= 3'h6;
    repeat (8) @(posedge pclk);
    check(32'(port_out[2:1]), 32'h1);
    ext_src <= 3'h0;
    repeat (8) @(posedge pclk);
    check(32'(port_out[2:1]), 32'h0);
    apb(1'b1, ppo_pkg::A_TIME, 32'h80);
    apb(1'b1, ppo_pkg::A_TRGT, 32'h100);
    apb(1'b1, ppo_pkg::A_TRGD, 32'h0);
    apb(1'b1, ppo_pkg::A_CTRL, 32'h6);
    repeat (4500) @(posedge pclk);
    apb(1'b0, ppo_pkg::A_STAT, 32'h0);
    check(q & 32'hA, 32'hA);
    apb(1'b1, ppo_pkg::A_CTRL, 32'h806);
    repeat (5) @(posedge pclk);
    check(32'(pulse_out), 32'h0);
    // Slow code: second 5 of the day low, minute only 2 s, hour 4 s
    apb(1'b1, ppo_pkg::A_CTRL, 32'h7);
    apb(1'b1, ppo_pkg::A_TIME, 32'h280);
    repeat (8) @(posedge pclk);
    check(32'(pulse_out), 32'h0);
    apb(1'b1, ppo_pkg::A_TIME, 32'h2280);
    repeat (8) @(posedge pclk);
    check(32'(pulse_out), 32'h1);
    apb(1'b1, ppo_pkg::A_TIME, 32'h8_0180);
    repeat (8) @(posedge pclk);
    check(32'(pulse_out), 32'h0);
    // Second 59: silent in long-wave, half second in the modified form
    apb(1'b1, ppo_pkg::A_CTRL, 32'h5);
    apb(1'b1, ppo_pkg::A_TIME, 32'h1D80);
    repeat (8) @(posedge pclk);
    check(32'(pulse_out), 32'h0);
    apb(1'b1, ppo_pkg::A_CTRL, 32'h4);
    apb(1'b1, ppo_pkg::A_TIME, 32'h1D80);
    repeat (1200) @(posedge pclk);
    check(32'(pulse_out), 32'h1);
    // Daily at 00:00:01.05, width 4 ticks
    apb(1'b1, ppo_pkg::A_WIDTH, 32'h4);
    apb(1'b1, ppo_pkg::A_DAY, 32'h85);
    apb(1'b1, ppo_pkg::A_CTRL, 32'h2);
    apb(1'b1, ppo_pkg::A_TIME, 32'h80);
    repeat (200) @(posedge pclk);
    check(near(last_width, 32'h50), 32'h1);
    // Mid-run reset restores the width register
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ppo_pkg::A_WIDTH, 32'h0);
    check(q, 32'h1);
    print_verdict();
  end
endmodule
`default_nettype wire
